// >>> pom_blink.sv
// Run indicator blink generator with a minimum-duration hold
`timescale 1ns/100ps
module pom_blink
  import pom_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic want,
  // Output
  output logic active,
  output logic phase
);

  logic [CNT_W-1:0] min_q;
  logic [CNT_W-1:0] half_q;
  logic phase_q;

  // Minimum duration counter, restarted by start
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      min_q <= '0;
    end else if (start) begin
      min_q <= CNT_W'(BLINK_MIN_CYC);
    end else if (min_q != '0) begin
      min_q <= min_q - 1'b1;
    end
  end

  // Square wave while blinking is shown
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_q <= '0;
      phase_q <= 1'b0;
    end else if (!active) begin
      half_q <= '0;
      phase_q <= 1'b1;
    end else if (half_q == CNT_W'(BLINK_HALF_CYC - 1)) begin
      half_q <= '0;
      phase_q <= ~phase_q;
    end else begin
      half_q <= half_q + 1'b1;
    end
  end

  assign active = want || (min_q != '0);
  assign phase = phase_q;

endmodule : pom_blink

// >>> pom_exec_model.sv
// Behavioural program executor answering the sequencer phase requests
`timescale 1ns/100ps
module pom_exec_model
  import pom_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Bench control: work length per phase, freeze in hold
  input wire logic [15:0] lag,
  input wire logic freeze,
  // Sequencer side
  input wire pom_req_s exec_req,
  input wire logic exec_step,
  output pom_done_s exec_done,
  output logic [PC_W-1:0] exec_pc
);
  // Work counter doubles as program address; a step moves it while frozen
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      exec_pc <= '0;
      exec_done <= '0;
    end else if (exec_done != '0) begin
      exec_pc <= '0; // Fresh count after every acknowledge
      exec_done <= '0;
    end else if (exec_pc >= lag) begin
      exec_done <= exec_req;
    end else if (freeze ? exec_step : (exec_req != '0)) begin
      exec_pc <= exec_pc + 16'h0001; // Held while nothing is ordered, unless a step comes while frozen
    end
  end
endmodule : pom_exec_model

// >>> pom_mode_ctrl.sv
// Operating mode sequencer for the controller CPU
`timescale 1ns/100ps

// Overview of operation
// - Exactly one of four modes: stop, start-up, run, hold.
// - Stop executes nothing; timers, counters, images kept as they were.
// - Stop asserts output disable; run lamp dark, stop lamp lit. Here the run lamp still blinks in stop until 3 s after handler start.
// - Stop to run calls start-up handler once, unsupervised.
// - Output disable held throughout start-up.
// - Run lamp blinks from handler start for at least 3 s.
// - Stop lamp lit during handler, dark once it ends.
// - Handler done moves straight into run.
// - After watchdog error, run needs cold-start handler, reset or reload.
// - Run repeats main program; timers run; images refreshed each cycle.
// - Run releases output disable; run lamp lit, stop lamp dark.
// - At most three breakpoints; the tool defines no more.
// - Reaching an active breakpoint enters hold; step or resume accepted.
// - Hold blinks run lamp, stop lamp lit, timers frozen, outputs off.
// - Single step refused when more than two breakpoints defined.
// - 100 ms watchdog and cycle limit of at least 1 ms force stop.
// - Leaving run, analog outputs go to zero, 4 mA or substitute.
// - Remote outputs follow local ones; remote inputs keep being read.
// - Start: clear input image, handler, release disable, clear outputs.
// - Each cycle reads inputs, runs main program, writes outputs.
// - Overall reset erases user memory, memory card untouched.
module pom_mode_ctrl
  import pom_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Mode requests (pins, synchronised here)
  input wire logic run_req,
  input wire logic overall_reset_req,
  input wire logic project_reload,
  // Configuration
  input wire logic cold_start_present,
  input wire logic [MS_W-1:0] cycle_limit_ms,
  // Program executor handshake
  output pom_req_s exec_req,
  input wire pom_done_s exec_done,
  input wire logic exec_error,
  input wire logic [PC_W-1:0] exec_pc,
  output logic exec_step,
  // Breakpoints from the programming tool
  input wire logic [BP_NUM-1:0] bp_valid,
  input wire logic [BP_NUM-1:0][PC_W-1:0] bp_addr,
  input wire logic bp_active,
  input wire logic step_req,
  input wire logic resume_req,
  // Outputs and status
  output logic command_output_disable,
  output logic timers_run,
  output logic user_mem_erase,
  output logic [AO_NUM-1:0][AO_W-1:0] ao_value,
  input wire pom_ao_kind_e [AO_NUM-1:0] ao_kind,
  input wire logic [AO_NUM-1:0][AO_W-1:0] ao_subst,
  input wire logic [AO_NUM-1:0][AO_W-1:0] ao_program,
  output pom_led_s leds,
  output logic [1:0] mode_status,
  output logic wdog_fault,
  output logic step_refused
);

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic run_s;
  logic mres_s;
  logic reload_s;
  logic step_s;
  logic resume_s;
  logic step_prev_q;
  logic resume_prev_q;

  // Two flops on every pin-level request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {resume_req, step_req, project_reload,
                  overall_reset_req, run_req};
      sync2_q <= sync1_q;
    end
  end

  assign run_s = sync2_q[0];
  assign mres_s = sync2_q[1];
  assign reload_s = sync2_q[2];
  assign step_s = sync2_q[3];
  assign resume_s = sync2_q[4];

  // Edge memory for tool requests
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_prev_q <= 1'b0;
      resume_prev_q <= 1'b0;
    end else begin
      step_prev_q <= step_s;
      resume_prev_q <= resume_s;
    end
  end

  logic step_evt;
  logic resume_evt;
  assign step_evt = step_s && !step_prev_q;
  assign resume_evt = resume_s && !resume_prev_q;

  // ****************************************************
  // State
  // ****************************************************
  pom_mode_e mode_q;
  pom_phase_e phase_q;
  logic wdog_lock_q;
  logic step_pend_q;
  logic bp_skip_q;
  logic fault;
  logic wd_exp;
  logic cyc_exp;
  logic bp_hit;
  logic [1:0] bp_count;
  logic step_ok;
  logic phase_done;
  logic [CNT_W-1:0] cyc_limit;

  // Breakpoint match and population count
  always_comb begin
    bp_hit = 1'b0;
    bp_count = '0;
    for (int i = 0; i < BP_NUM; i++) begin
      if (bp_valid[i]) begin
        bp_count = bp_count + 2'd1;
        if (bp_addr[i] == exec_pc) begin
          bp_hit = bp_active;
        end
      end
    end
  end

  assign step_ok = (bp_count <= 2'(BP_STEP_MAX));

  // Completion of the phase currently ordered
  always_comb begin
    case (phase_q)
      POM_PH_CLR_IN: phase_done = exec_done.clr_in;
      POM_PH_STARTUP: phase_done = exec_done.startup;
      POM_PH_CLR_OUT: phase_done = exec_done.clr_out;
      POM_PH_READ_IN: phase_done = exec_done.read_in;
      POM_PH_MAIN: phase_done = exec_done.main;
      POM_PH_WRITE_OUT: phase_done = exec_done.write_out;
      default: phase_done = 1'b0;
    endcase
  end

  // Supervision faults collapse into one stop cause
  assign fault = wd_exp || cyc_exp || exec_error;

  // ****************************************************
  // Mode sequencer
  // ****************************************************
  // Mode and phase advance together so order is never broken
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= POM_STOP;
      phase_q <= POM_PH_IDLE;
    end else begin
      case (mode_q)
        POM_STOP: begin
          phase_q <= POM_PH_IDLE;
          if (run_s && !mres_s && (!wdog_lock_q || cold_start_present)) begin
            mode_q <= POM_STARTUP;
            phase_q <= POM_PH_CLR_IN;
          end
        end
        POM_STARTUP: begin
          if (!run_s || exec_error) begin
            mode_q <= POM_STOP;
            phase_q <= POM_PH_IDLE;
          end else if (phase_done && phase_q == POM_PH_CLR_IN) begin
            phase_q <= POM_PH_STARTUP;
          end else if (phase_done) begin
            mode_q <= POM_RUN;
            phase_q <= POM_PH_CLR_OUT;
          end
        end
        POM_RUN: begin
          if (!run_s || fault) begin
            mode_q <= POM_STOP;
            phase_q <= POM_PH_IDLE;
          end else if (phase_q == POM_PH_MAIN && bp_hit && !bp_skip_q) begin
            mode_q <= POM_HOLD;
          end else if (phase_done) begin
            case (phase_q)
              POM_PH_CLR_OUT: phase_q <= POM_PH_READ_IN;
              POM_PH_READ_IN: phase_q <= POM_PH_MAIN;
              POM_PH_MAIN: phase_q <= POM_PH_WRITE_OUT;
              default: phase_q <= POM_PH_READ_IN;
            endcase
          end
        end
        POM_HOLD: begin
          if (!run_s) begin
            mode_q <= POM_STOP;
            phase_q <= POM_PH_IDLE;
          end else if (resume_evt) begin
            mode_q <= POM_RUN;
          end
        end
        default: begin
          mode_q <= POM_STOP;
          phase_q <= POM_PH_IDLE;
        end
      endcase
    end
  end

  // Single step pulses the executor once; the mode stays in hold
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_pend_q <= 1'b0;
    end else begin
      step_pend_q <= (mode_q == POM_HOLD) && step_evt && step_ok;
    end
  end

  // Skip the breakpoint just left, until the pc moves on
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bp_skip_q <= 1'b0;
    end else if (mode_q == POM_HOLD) begin
      bp_skip_q <= 1'b1;
    end else if (!bp_hit) begin
      bp_skip_q <= 1'b0; // Armed again once the pc has moved on
    end
  end

  // Watchdog lock survives until a reset or reload clears it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_lock_q <= 1'b0;
    end else if (mode_q == POM_RUN && wd_exp) begin
      wdog_lock_q <= 1'b1; // set wins over clear
    end else if (mres_s || reload_s) begin
      wdog_lock_q <= 1'b0;
    end
  end

  // ****************************************************
  // Supervision
  // ****************************************************
  // Kicked at every cycle end, when the output write completes; hold and start-up are not watched
  logic sup_arm;
  logic cyc_kick;
  assign sup_arm = (mode_q == POM_RUN);
  assign cyc_kick = phase_done && (phase_q == POM_PH_WRITE_OUT);
  // Limit never below the 1 ms floor
  assign cyc_limit = (cycle_limit_ms < MS_W'(CYC_MIN_MS))
    ? CNT_W'(CYC_MIN_MS * CYC_PER_MS)
    : CNT_W'(cycle_limit_ms) * CNT_W'(CYC_PER_MS);

  pom_wdog u_wdog (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .arm(sup_arm),
    .kick(cyc_kick),
    .limit(CNT_W'(WDOG_CYC)),
    .expired(wd_exp)
  );

  pom_wdog u_cyc (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .arm(sup_arm),
    .kick(cyc_kick),
    .limit(cyc_limit),
    .expired(cyc_exp)
  );

  // ****************************************************
  // Indicators
  // ****************************************************
  logic blink_start;
  logic blink_on;
  logic blink_ph;
  logic handler_q;

  // Start pulse on entering the handler phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      handler_q <= 1'b0;
    end else begin
      handler_q <= (phase_q == POM_PH_STARTUP);
    end
  end
  assign blink_start = (phase_q == POM_PH_STARTUP) && !handler_q;

  pom_blink u_blink (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(blink_start),
    .want(mode_q == POM_HOLD),
    .active(blink_on),
    .phase(blink_ph)
  );

  // Lamps registered so they never glitch
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      leds <= '{run_led: 1'b0, stop_led: 1'b1};
    end else begin
      leds.run_led <= blink_on ? blink_ph : (mode_q == POM_RUN);
      leds.stop_led <= (mode_q == POM_STOP) || (mode_q == POM_HOLD)
        || (phase_q == POM_PH_CLR_IN)
        || (phase_q == POM_PH_STARTUP);
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Disable released only when run is reached
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      command_output_disable <= 1'b1;
      timers_run <= 1'b0;
      mode_status <= POM_STOP;
      user_mem_erase <= 1'b0;
      exec_step <= 1'b0;
      step_refused <= 1'b0;
      wdog_fault <= 1'b0;
    end else begin
      command_output_disable <= (mode_q != POM_RUN);
      timers_run <= (mode_q == POM_RUN);
      mode_status <= mode_q;
      user_mem_erase <= mres_s && (mode_q == POM_STOP);
      exec_step <= step_pend_q;
      step_refused <= (mode_q == POM_HOLD) && step_evt && !step_ok;
      wdog_fault <= wdog_lock_q;
    end
  end

  // Analog fallback values while disabled, shared by remote stations
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ao_value <= '0;
    end else begin
      for (int i = 0; i < AO_NUM; i++) begin
        if (mode_q == POM_RUN) begin
          ao_value[i] <= ao_program[i];
        end else begin
          case (ao_kind[i])
            POM_AO_I420: ao_value[i] <= AO_FOUR_MA;
            POM_AO_SUBST: ao_value[i] <= ao_subst[i];
            default: ao_value[i] <= AO_ZERO;
          endcase
        end
      end
    end
  end

  // Phase orders to the executor, one hot, none while stopped
  always_comb begin
    exec_req = '0;
    exec_req.clr_in = (phase_q == POM_PH_CLR_IN);
    exec_req.startup = (phase_q == POM_PH_STARTUP);
    exec_req.clr_out = (mode_q == POM_RUN) && (phase_q == POM_PH_CLR_OUT);
    exec_req.read_in = (mode_q == POM_RUN) && (phase_q == POM_PH_READ_IN);
    exec_req.main = (mode_q == POM_RUN) && (phase_q == POM_PH_MAIN);
    exec_req.write_out = (mode_q == POM_RUN)
      && (phase_q == POM_PH_WRITE_OUT);
  end

endmodule : pom_mode_ctrl

// >>> pom_mode_ctrl_monitor.sv
// Checker of mode, lamp, phase and step relations at the sequencer ports
`timescale 1ns/100ps
module pom_mode_ctrl_monitor
  import pom_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Executor and breakpoints
  input wire pom_req_s exec_req,
  input wire pom_done_s exec_done,
  input wire logic exec_step,
  input wire logic [BP_NUM-1:0] bp_valid,
  // Status
  input wire logic command_output_disable,
  input wire logic timers_run,
  input wire logic user_mem_erase,
  input wire pom_led_s leds,
  input wire logic [1:0] mode_status,
  input wire logic step_refused
);
  // ********
  // Assertions
  // ********
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_reset_in_stop: assert property (
    $rose(arst_n) |-> mode_status == POM_STOP && command_output_disable)
    else $error("mode not stopped after reset");
  a_stop_outputs_off: assert property (
    mode_status == POM_STOP |-> command_output_disable && leds.stop_led)
    else $error("stop without output disable or stop lamp");
  a_startup_disable: assert property (
    mode_status == POM_STARTUP |-> command_output_disable)
    else $error("outputs enabled during start-up");
  a_run_lamps: assert property (
    mode_status == POM_RUN |-> !command_output_disable && !leds.stop_led)
    else $error("run with outputs off or stop lamp lit");
  a_hold_frozen: assert property (
    mode_status == POM_HOLD && $past(mode_status) == POM_HOLD |->
      !timers_run && command_output_disable && leds.stop_led)
    else $error("hold not frozen");
  a_phase_onehot: assert property (
    $onehot0(exec_req))
    else $error("more than one phase requested");
  a_handler_order: assert property (
    $rose(exec_req.startup) |-> $past(exec_done.clr_in))
    else $error("handler before input clear");
  a_clear_out_order: assert property (
    $rose(exec_req.clr_out) |-> $past(exec_done.startup))
    else $error("output clear before handler end");
  a_write_after_main: assert property (
    $rose(exec_req.write_out) |-> $past(exec_done.main))
    else $error("output write before main program end");
  a_step_refusal: assert property (
    step_refused |-> $countones(bp_valid) > BP_STEP_MAX ##1 !step_refused)
    else $error("step refusal wrong");
  a_step_allowed: assert property (
    exec_step |-> $countones(bp_valid) <= BP_STEP_MAX ##1 !exec_step)
    else $error("step issued with too many breakpoints");
  a_erase_in_stop: assert property (
    user_mem_erase |-> mode_status == POM_STOP)
    else $error("memory erase outside stop");
endmodule : pom_mode_ctrl_monitor

bind pom_mode_ctrl pom_mode_ctrl_monitor u_mon (
  .core_clk, .arst_n, .exec_req, .exec_done, .exec_step, .bp_valid,
  .command_output_disable, .timers_run, .user_mem_erase, .leds,
  .mode_status, .step_refused);

// >>> pom_pkg.sv
// Package with modes, phases, timing constants and carrier structs
package pom_pkg;

  // ****************************************************
  // Operating modes and cycle phases
  // ****************************************************
  typedef enum logic [1:0] {
    POM_STOP    = 2'b00,
    POM_STARTUP = 2'b01,
    POM_RUN     = 2'b10,
    POM_HOLD    = 2'b11
  } pom_mode_e;

  typedef enum logic [2:0] {
    POM_PH_IDLE     = 3'b000,
    POM_PH_CLR_IN   = 3'b001,
    POM_PH_STARTUP  = 3'b010,
    POM_PH_CLR_OUT  = 3'b011,
    POM_PH_READ_IN  = 3'b100,
    POM_PH_MAIN     = 3'b101,
    POM_PH_WRITE_OUT = 3'b110
  } pom_phase_e;

  // Analog output fallback kinds
  typedef enum logic [1:0] {
    POM_AO_VOLT  = 2'b00,
    POM_AO_I020  = 2'b01,
    POM_AO_I420  = 2'b10,
    POM_AO_SUBST = 2'b11
  } pom_ao_kind_e;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned WDOG_MS = 100;
  localparam int unsigned CYC_MIN_MS = 1;
  localparam int unsigned BLINK_MIN_S = 3;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned WDOG_CYC = WDOG_MS * CYC_PER_MS;
  localparam int unsigned BLINK_MIN_CYC = BLINK_MIN_S * CLK_HZ;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
  localparam int unsigned CYC_LIMIT_DEF_MS = 150;
  localparam int CNT_W = 32;
  localparam int MS_W = 16;

  // ****************************************************
  // Breakpoints and analog codes
  // ****************************************************
  localparam int BP_NUM = 3;
  localparam int BP_STEP_MAX = 2;
  localparam int PC_W = 16;
  localparam int AO_NUM = 4;
  localparam int AO_W = 16;
  localparam logic [AO_W-1:0] AO_ZERO = 16'h0000;
  localparam logic [AO_W-1:0] AO_FOUR_MA = 16'h1999;

  // Program executor handshake, one group per phase
  typedef struct packed {
    logic clr_in;
    logic startup;
    logic clr_out;
    logic read_in;
    logic main;
    logic write_out;
  } pom_req_s;

  typedef struct packed {
    logic clr_in;
    logic startup;
    logic clr_out;
    logic read_in;
    logic main;
    logic write_out;
  } pom_done_s;

  typedef struct packed {
    logic run_led;
    logic stop_led;
  } pom_led_s;

endpackage : pom_pkg

// >>> pom_wdog.sv
// Up-counting supervision timer used for watchdog and cycle limit
`timescale 1ns/100ps
module pom_wdog
  import pom_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control
  input wire logic arm,
  input wire logic kick,
  input wire logic [CNT_W-1:0] limit,
  // Status
  output logic expired
);

  logic [CNT_W-1:0] cnt_q;

  // Reload on kick, count while armed, park when disarmed
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (!arm || kick) begin
      cnt_q <= '0;
    end else if (cnt_q < limit) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Expiry is a level until disarmed or kicked; a bound so a lowered
  // limit still trips
  assign expired = arm && (cnt_q >= limit);

endmodule : pom_wdog

// >>> tb_pom_mode_ctrl.sv
// Self-checking bench for the operating mode sequencer
`timescale 1ns/100ps
module tb_pom_mode_ctrl;
  import pom_pkg::*;
  // ********
  // Stimulus, outputs and bookkeeping
  // ********
  logic core_clk = 1'b0, arst_n = 1'b0, run_req = 1'b0;
  logic overall_reset_req = 1'b0, exec_error = 1'b0, bp_active = 1'b0;
  logic step_req = 1'b0, resume_req = 1'b0;
  logic [MS_W-1:0] cycle_limit_ms = 16'h0096;
  logic [BP_NUM-1:0] bp_valid = 3'h0;
  logic [BP_NUM-1:0][PC_W-1:0] bp_addr = '0;
  pom_ao_kind_e [AO_NUM-1:0] ao_kind = '{POM_AO_SUBST, POM_AO_I420,
    POM_AO_I020, POM_AO_VOLT};
  logic [AO_NUM-1:0][AO_W-1:0] ao_subst = {16'h0abc, {3{16'h0fff}}};
  logic [AO_NUM-1:0][AO_W-1:0] ao_program = {4{16'h7777}};
  localparam logic [AO_NUM-1:0][AO_W-1:0] EXP_AO = {16'h0abc, AO_FOUR_MA,
    AO_ZERO, AO_ZERO};
  logic [15:0] lag = 16'h0008;
  pom_req_s exec_req;
  pom_done_s exec_done;
  pom_led_s leds;
  logic [PC_W-1:0] exec_pc;
  logic [AO_NUM-1:0][AO_W-1:0] ao_value;
  logic [1:0] mode_status;
  logic exec_step, command_output_disable, timers_run;
  logic user_mem_erase, step_refused, wdog_fault;
  int miscompares = 0, n_compared = 0;
  int cyc = 0, last_wr = 0, n_step = 0, n_ref = 0;

  always #25 core_clk = ~core_clk;

  pom_mode_ctrl u_dut (.core_clk, .arst_n, .run_req, .overall_reset_req,
    .project_reload(1'b0), .cold_start_present(1'b0), .cycle_limit_ms,
    .exec_req, .exec_done, .exec_error, .exec_pc, .exec_step, .bp_valid,
    .bp_addr, .bp_active, .step_req, .resume_req, .command_output_disable,
    .timers_run, .user_mem_erase, .ao_value, .ao_kind, .ao_subst,
    .ao_program, .leds, .mode_status, .wdog_fault, .step_refused);

  // Far side freezes only once hold is visible, as a real executor would
  pom_exec_model u_exec (.core_clk, .arst_n, .lag,
    .freeze(mode_status == POM_HOLD), .exec_req, .exec_step, .exec_done,
    .exec_pc);

  // Cycle count, last output write and pulse tallies
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (exec_done.write_out) last_wr <= cyc;
    if (exec_step) n_step <= n_step + 1;
    if (step_refused) n_ref <= n_ref + 1;
  end

  // ********
  // Tasks
  // ********
  task automatic cmp_bit(input logic got, input logic exp, input string s);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %b", $time, s, got);
    end
  endtask : cmp_bit

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp,
    input string s);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h", $time, s, got);
    end
  endtask : cmp_val

  // Bounded wait for a mode, then compare it
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int i;
    i = 0;
    while (mode_status !== m && i < lim) begin
      @(posedge core_clk);
      i++;
    end
    cmp_val({14'h0000, mode_status}, {14'h0000, m}, "mode");
  endtask : wait_mode

  // Level request long enough to pass the two-flop synchroniser
  task automatic pulse(input bit resume);
    if (resume) resume_req <= 1'b1;
    else step_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    resume_req <= 1'b0;
    step_req <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : pulse

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // ********
  // Tests
  // ********
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    wait_mode(POM_STOP, 1);
    cmp_bit(command_output_disable, 1'b1, "reset disable");
    cmp_bit(leds.stop_led, 1'b1, "reset stop lamp");
    cmp_bit(leds.run_led, 1'b0, "reset run lamp");
    $display("test reset done");
    run_req <= 1'b1;
    wait_mode(POM_STARTUP, 50);
    cmp_bit(command_output_disable, 1'b1, "startup disable");
    cmp_bit(leds.stop_led, 1'b1, "startup stop lamp");
    wait_mode(POM_RUN, 80);
    cmp_bit(command_output_disable, 1'b0, "run disable");
    cmp_bit(leds.stop_led, 1'b0, "run stop lamp");
    cmp_bit(leds.run_led, 1'b1, "run lamp");
    cmp_val(ao_value[0], 16'h7777, "ao in run");
    repeat (100) @(posedge core_clk);
    cmp_bit(timers_run, 1'b1, "timers in run");
    cmp_bit(cyc - last_wr < 40, 1'b1, "cycles repeat");
    $display("test start done");
    // One breakpoint: hold, one step, resume
    bp_addr <= {16'h0000, 16'h0000, 16'h0002};
    bp_valid <= 3'b001;
    bp_active <= 1'b1;
    wait_mode(POM_HOLD, 100);
    cmp_bit(command_output_disable, 1'b1, "hold disable");
    cmp_bit(leds.stop_led, 1'b1, "hold stop lamp");
    repeat (2) @(posedge core_clk);
    cmp_bit(timers_run, 1'b0, "hold timers");
    pulse(1'b0);
    cmp_bit(n_step == 1, 1'b1, "one step");
    wait_mode(POM_HOLD, 1);
    pulse(1'b1);
    wait_mode(POM_RUN, 100);
    // Three breakpoints: a step is refused
    bp_valid <= 3'b111;
    wait_mode(POM_HOLD, 100);
    pulse(1'b0);
    cmp_bit(n_ref == 1 && n_step == 1, 1'b1, "step refused");
    bp_active <= 1'b0;
    bp_valid <= 3'b000;
    pulse(1'b1);
    wait_mode(POM_RUN, 100);
    $display("test breakpoints done");
    run_req <= 1'b0;
    wait_mode(POM_STOP, 50);
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < AO_NUM; i++)
      cmp_val(ao_value[i], EXP_AO[i], "ao");
    cmp_bit(timers_run, 1'b0, "stop timers");
    $display("test stop done");
    run_req <= 1'b1;
    wait_mode(POM_RUN, 100);
    exec_error <= 1'b1;
    wait_mode(POM_STOP, 20);
    exec_error <= 1'b0;
    run_req <= 1'b0;
    repeat (20) @(posedge core_clk);
    $display("test error done");
    // Limit below 1 ms is taken as 1 ms
    cycle_limit_ms <= 16'h0000;
    run_req <= 1'b1;
    wait_mode(POM_RUN, 100);
    repeat (60) @(posedge core_clk);
    lag <= 16'h7530;
    wait_mode(POM_STOP, 25000);
    cmp_bit(cyc - last_wr >= CYC_PER_MS - 5 &&
      cyc - last_wr < CYC_PER_MS + 20, 1'b1, "cycle limit");
    cmp_bit(wdog_fault, 1'b0, "no lock after cycle limit");
    run_req <= 1'b0;
    lag <= 16'h0008;
    repeat (20) @(posedge core_clk);
    $display("test cycle limit done");
    overall_reset_req <= 1'b1;
    repeat (10) @(posedge core_clk);
    cmp_bit(user_mem_erase, 1'b1, "erase in stop");
    run_req <= 1'b1;
    repeat (20) @(posedge core_clk);
    wait_mode(POM_STOP, 1);
    run_req <= 1'b0;
    repeat (5) @(posedge core_clk);
    overall_reset_req <= 1'b0;
    repeat (10) @(posedge core_clk);
    cmp_bit(user_mem_erase, 1'b0, "erase ends");
    $display("test overall reset done");
    give_verdict();
  end

  // Watchdog: the tests need about 21000 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    $display("mismatch at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule : tb_pom_mode_ctrl
